// *** core/fstc_core.sv ***
/*
 * fstc_core: status/control register, trap decision, mode sequencing,
 * fetch/decode front end, two-entry op_queue and dependency freeze.
 * Assumes the integer core pulses core_issue for a decoded arithmetic
 * op or load/store, and the datapath reports each completion once.
 */
`timescale 1ns/100ps
// Contract
// - after reset only version and reserved bits are defined, being hard-wired; the code resets every other field to zero.
// - bits 31:30 pick rounding: nearest-even, zero, plus infinity, minus infinity.
// - reserved bits 29:28, 21:20 and 12 always read zero.
// - bits 27:23 enable traps for invalid, overflow, underflow, divide-zero, inexact.
// - raise an IEEE trap when enable mask AND current flags is nonzero.
// - masked exceptions are ORed into accrued flags in bits 9:5.
// - each operation's exceptions are shown in current flags, bits 4:0.
// - masked operations write the register file; trapping operations do not.
// - flush bit makes multiply, divide, square root treat subnormals as zero.
// - flush multiply: subnormal input gives zero silently; subnormal result underflows.
// - flush divide gives zero, infinity with divide-zero, NaN invalid, or underflow.
// - flush square root of subnormal returns zero with no exception.
// - version bits 19:17 are read-only and fixed.
// - trap type bits 16:14 written at every completion, zero when normal.
// - queue flag bit 13 shows nonempty queue; store reads zero in execution.
// - compares set bits 11:10: equal, less, greater, unordered.
// - status load writes only rounding, enables, flush, compare, accrued, current.
// - capture instructions from buses; start on the integer core's issue signal.
// - op_queue holds two entries of instruction and address.
// - freeze the pipeline while an incoming instruction depends on queued work.
// - stages fetch, decode, execute, write; fetch always before decode.
// - register file of 32 registers, 32 bits each, feeds operands.
// - trap request enters pending; next issue moves to exception mode.
// - exception mode drains the queue, then returns to execution.
// - on a trap only the exception-describing status fields change.
module fstc_core
   import fstc_pkg::*;
#(
   parameter logic [2:0] VERSION = 3'h5  // arbitrary version code
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       fetch_strobe,
   input  wire logic [31:0] data_bus,
   input  wire logic [31:0] addr_bus,
   input  wire logic       core_issue,
   input  wire logic       load_status_cmd,
   input  wire logic [31:0] load_status_data,
   input  wire logic       store_status_cmd,
   input  wire logic       queue_store_cmd,
   input  wire logic       ld_we,
   input  wire logic [4:0] ld_rd,
   input  wire logic [31:0] ld_data,
   input  wire logic [4:0] op_raddr,
   input  wire logic       done,
   input  wire fstc_done_t done_info,
   output logic [31:0]     op_rdata,
   output logic            exec_start,
   output fstc_qent_t      exec_op,
   output logic            freeze,
   output logic            trap_req,
   output logic            trap_taken,
   output logic [31:0]     store_data,
   output logic            store_valid,
   output fstc_qent_t      queue_out,
   output logic            queue_out_valid,
   output logic [1:0]      round_mode,
   output logic            flush_mode,
   output fstc_mode_t      mode
);
   logic [1:0]  rnd_q;
   logic [4:0]  tem_q;
   logic        ns_q;
   logic [2:0]  ftt_q;
   logic [1:0]  fcc_q;
   logic [4:0]  accrued_flags_q;
   logic [4:0]  current_flags_q;
   logic [31:0] f_instr_q;
   logic [31:0] f_addr_q;
   logic        f_valid_q;
   fstc_qent_t  d_ent_q;
   logic        d_valid_q;
   logic        pend_q;
   fstc_qent_t  q_q [QDEPTH];
   logic [1:0]  cnt_q;
   logic [31:0] fr_res;
   logic [4:0]  fr_exc;

   // true when the incoming op reads or writes the queued op's target
   function automatic logic dep_hit(input fstc_qent_t q, input logic [31:0] ins);
      logic [4:0] qd;
      qd = q.instr[INS_RD_LSB +: 5];
      dep_hit = (ins[INS_RS1_LSB +: 5] == qd) || (ins[INS_RS2_LSB +: 5] == qd)
                || (ins[INS_RD_LSB +: 5] == qd);
   endfunction

   // status word as software sees it; hard-wired bits are constants
   function automatic logic [31:0] status_word(input logic queue_pending_flag);
      status_word = 32'h00000000;
      status_word[RND_LSB +: 2]  = rnd_q;
      status_word[TEM_LSB +: 5]  = tem_q;
      status_word[NS_BIT]        = ns_q;
      status_word[VER_LSB +: 3]  = VERSION;
      status_word[FTT_LSB +: 3]  = ftt_q;
      status_word[QNE_BIT]       = queue_pending_flag;
      status_word[FCC_LSB +: 2]  = fcc_q;
      status_word[ACCRUED_FLAGS_LSB +: 5] = accrued_flags_q;
      status_word[CURRENT_FLAGS_LSB +: 5] = current_flags_q;
   endfunction

   // abrupt-underflow substitution on the completing op
   fstc_flush u_flush (
      .ns  (ns_q),
      .din (done_info),
      .res (fr_res),
      .exc (fr_exc)
   );

   // completion decode; completions are ignored outside execution mode
   // so a trapped machine stays frozen for the handler
   wire logic       fire     = done && (mode == FSTC_M_EXEC) && (cnt_q != 2'h0);
   wire logic [4:0] trig     = tem_q & fr_exc;
   wire logic       ieee_tr  = |trig;
   wire logic       other_tr = done_info.unfin | done_info.unimp;
   wire logic       trap_now = fire & (ieee_tr | other_tr);
   wire logic       is_cmp   = (done_info.kind == FSTC_K_CMP);
   wire logic       rf_wr    = fire & ~trap_now & ~is_cmp;
   wire logic [2:0] tt_code  = done_info.unimp ? TT_UNIMP :
                               done_info.unfin ? TT_UNFIN :
                               ieee_tr         ? TT_IEEE : TT_NONE;

   // front end: dependency check against every queued entry
   wire logic dep   = ((cnt_q > 2'h0) && dep_hit(q_q[0], d_ent_q.instr)) ||
                      ((cnt_q > 2'h1) && dep_hit(q_q[1], d_ent_q.instr));
   wire logic full  = (cnt_q == 2'(QDEPTH));
   wire logic want  = pend_q | (core_issue & (mode != FSTC_M_PEND));
   wire logic start = want & d_valid_q & ~dep & ~full & (mode == FSTC_M_EXEC);
   wire logic pop   = fire | (queue_store_cmd & (mode == FSTC_M_EXCP) & (cnt_q != 2'h0));
   wire logic take  = core_issue & (mode == FSTC_M_PEND);
   wire logic ld_ok = load_status_cmd & ~trap_now;

   // one op may complete from the head while another starts at the tail
   wire logic [1:0] cnt_d = cnt_q + {1'b0, start} - {1'b0, pop};

   // operand register file; arithmetic results on port b
   fstc_regfile #(
      .WIDTH (32),
      .DEPTH (32)
   ) u_rf (
      .clk     (clk),
      .wa_en   (ld_we),
      .wa_addr (ld_rd),
      .wa_data (ld_data),
      .wb_en   (rf_wr),
      .wb_addr (done_info.rd),
      .wb_data (fr_res),
      .r_addr  (op_raddr),
      .r_data  (op_rdata)
   );

   // fetch stage: capture instruction and address from the shared buses
   always_ff @(posedge clk) begin
      if (rst) begin
         f_valid_q <= 1'b0;
         f_instr_q <= 32'h00000000;
         f_addr_q  <= 32'h00000000;
      end else begin
         f_valid_q <= fetch_strobe;
         if (fetch_strobe) begin
            f_instr_q <= data_bus;
            f_addr_q  <= addr_bus;
         end
      end
   end

   // decode stage follows fetch by at least one cycle; a held decode
   // is not overwritten while an issued op waits on a dependency
   always_ff @(posedge clk) begin
      if (rst) begin
         d_valid_q <= 1'b0;
         d_ent_q   <= '0;
      end else if (f_valid_q && !pend_q) begin
         d_valid_q <= 1'b1;
         d_ent_q   <= '{instr: f_instr_q, addr: f_addr_q};
      end
   end

   // issued op waiting for the freeze to lift
   always_ff @(posedge clk) begin
      if (rst)
         pend_q <= 1'b0;
      else
         pend_q <= want & ~start & (mode == FSTC_M_EXEC);
   end

   // op_queue: two entries, head is entry 0
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q  <= 2'h0;
         q_q[0] <= '0;
         q_q[1] <= '0;
      end else begin
         cnt_q <= cnt_d;
         if (pop)
            q_q[0] <= q_q[1];
         if (start) begin
            if (cnt_d == 2'h1)
               q_q[0] <= d_ent_q;
            else
               q_q[1] <= d_ent_q;
         end
      end
   end

   // operating mode sequencing
   always_ff @(posedge clk) begin
      if (rst) begin
         mode <= FSTC_M_EXEC;
      end else begin
         unique case (mode)
            FSTC_M_EXEC: begin
               if (trap_now)
                  mode <= FSTC_M_PEND;
            end
            FSTC_M_PEND: begin
               if (take)
                  mode <= FSTC_M_EXCP;
            end
            FSTC_M_EXCP: begin
               if (cnt_q == 2'h0)
                  mode <= FSTC_M_EXEC;
            end
            default: mode <= FSTC_M_EXEC;
         endcase
      end
   end

   // loadable control fields; a trap leaves them untouched
   always_ff @(posedge clk) begin
      if (rst) begin
         rnd_q <= RST_RND;
         tem_q <= RST_TEM;
         ns_q  <= 1'b0;
      end else if (ld_ok) begin
         rnd_q <= load_status_data[RND_LSB +: 2];
         tem_q <= load_status_data[TEM_LSB +: 5];
         ns_q  <= load_status_data[NS_BIT];
      end
   end

   // exception-describing fields; completion outranks a same-cycle load, but accrued flags OR the loaded value with masked flags
   always_ff @(posedge clk) begin
      if (rst) begin
         ftt_q  <= TT_NONE;
         fcc_q  <= RST_FCC;
         accrued_flags_q <= RST_EXC;
         current_flags_q <= RST_EXC;
      end else if (fire) begin
         ftt_q  <= tt_code;
         current_flags_q <= fr_exc;
         if (!trap_now) begin
            accrued_flags_q <= (ld_ok ? load_status_data[ACCRUED_FLAGS_LSB +: 5] : accrued_flags_q)
                      | (fr_exc & ~tem_q);
            if (is_cmp)
               fcc_q <= done_info.fcc;
         end
      end else if (ld_ok) begin
         fcc_q  <= load_status_data[FCC_LSB +: 2];
         accrued_flags_q <= load_status_data[ACCRUED_FLAGS_LSB +: 5];
         current_flags_q <= load_status_data[CURRENT_FLAGS_LSB +: 5];
      end
   end

   // store of the status word; queue flag forced low in execution mode
   // even while ops are still queued; the flag reports only entries left for the handler
   always_ff @(posedge clk) begin
      if (rst) begin
         store_valid <= 1'b0;
         store_data  <= 32'h00000000;
      end else begin
         store_valid <= store_status_cmd;
         if (store_status_cmd)
            store_data <= status_word((mode != FSTC_M_EXEC) && (cnt_q != 2'h0));
      end
   end

   // queue drain port for the trap handler
   always_ff @(posedge clk) begin
      if (rst) begin
         queue_out_valid <= 1'b0;
         queue_out       <= '0;
      end else begin
         queue_out_valid <= pop & ~fire;
         if (pop && !fire)
            queue_out <= q_q[0];
      end
   end

   // handshake outputs to the integer core and datapath
   always_ff @(posedge clk) begin
      if (rst) begin
         exec_start <= 1'b0;
         exec_op    <= '0;
         freeze     <= 1'b0;
         trap_req   <= 1'b0;
         trap_taken <= 1'b0;
      end else begin
         exec_start <= start;
         if (start)
            exec_op <= d_ent_q;
         freeze     <= want & ~start & (mode == FSTC_M_EXEC);
         trap_req   <= trap_now | (trap_req & ~take);
         trap_taken <= take;
      end
   end

   // configuration seen by the arithmetic datapath
   always_ff @(posedge clk) begin
      if (rst) begin
         round_mode <= RST_RND;
         flush_mode <= 1'b0;
      end else begin
         round_mode <= rnd_q;
         flush_mode <= ns_q;
      end
   end
endmodule

// *** core/fstc_flush.sv ***
/*
 * fstc_flush: abrupt-underflow substitution for multiply, divide and
 * square root while the flush bit is set. Purely combinational.
 * Assumes operand and result class bits come from the datapath.
 */
`timescale 1ns/100ps
module fstc_flush
   import fstc_pkg::*;
(
   input  wire logic       ns,
   input  wire fstc_done_t din,
   output logic [31:0]     res,
   output logic [4:0]      exc
);
   wire logic a_sz  = din.a_sub | din.a_zero;
   wire logic b_sz  = din.b_sub | din.b_zero;
   wire logic any_s = din.a_sub | din.b_sub;
   wire logic mul   = ns & (din.kind == FSTC_K_MUL);
   wire logic div   = ns & (din.kind == FSTC_K_DIV);
   wire logic sqr   = ns & (din.kind == FSTC_K_SQRT);

   // divide cases are tested in priority: both small, divisor, dividend
   always_comb begin
      res = din.res;
      exc = din.exc;
      if (mul && any_s) begin
         res = RES_ZERO;
         exc = 5'h00;
      end else if (div && any_s && a_sz && b_sz) begin
         res = RES_NAN;
         exc = 5'h10;
      end else if (div && din.b_sub) begin
         res = RES_INF;
         exc = 5'h02;
      end else if (div && din.a_sub) begin
         res = RES_ZERO;
         exc = 5'h00;
      end else if (sqr && din.a_sub) begin
         res = RES_ZERO;
         exc = 5'h00;
      end else if ((mul || div || sqr) && din.r_sub) begin
         res = RES_ZERO;
         exc = 5'h04;
      end
   end
endmodule

// *** core/fstc_pkg.sv ***
/*
 * fstc_pkg: shared constants and carrier types for the floating-point
 * status and trap control block.
 * Assumes a single 10 MHz processor clock and 32-bit instruction words.
 */
package fstc_pkg;
   // status word field positions
   localparam int RND_LSB  = 30;
   localparam int TEM_LSB  = 23;
   localparam int NS_BIT   = 22;
   localparam int VER_LSB  = 17;
   localparam int FTT_LSB  = 14;
   localparam int QNE_BIT  = 13;
   localparam int FCC_LSB  = 10;
   localparam int ACCRUED_FLAGS_LSB = 5;
   localparam int CURRENT_FLAGS_LSB = 0;
   // exception bit order inside every 5-bit group
   localparam int EX_NV = 4;
   localparam int EX_OF = 3;
   localparam int EX_UF = 2;
   localparam int EX_DZ = 1;
   localparam int EX_NX = 0;
   // rounding encodings
   localparam logic [1:0] RND_NEAR = 2'h0;
   localparam logic [1:0] RND_ZERO = 2'h1;
   localparam logic [1:0] RND_PINF = 2'h2;
   localparam logic [1:0] RND_MINF = 2'h3;
   // trap type encodings
   localparam logic [2:0] TT_NONE  = 3'h0;
   localparam logic [2:0] TT_IEEE  = 3'h1;
   localparam logic [2:0] TT_UNFIN = 3'h2;
   localparam logic [2:0] TT_UNIMP = 3'h3;
   localparam logic [2:0] TT_SEQ   = 3'h4;
   // values after reset of the loadable fields
   localparam logic [1:0] RST_RND  = 2'h0;
   localparam logic [4:0] RST_TEM  = 5'h00;
   localparam logic [1:0] RST_FCC  = 2'h0;
   localparam logic [4:0] RST_EXC  = 5'h00;
   // instruction field positions used by decode
   localparam int INS_RD_LSB  = 25;
   localparam int INS_RS1_LSB = 14;
   localparam int INS_RS2_LSB = 0;
   localparam int INS_OP_LSB  = 5;
   // flush-mode result constants (single precision)
   localparam logic [31:0] RES_ZERO = 32'h00000000;
   localparam logic [31:0] RES_INF  = 32'h7F800000;
   localparam logic [31:0] RES_NAN  = 32'h7FC00000;
   localparam int QDEPTH = 2;

   typedef enum logic [2:0] {
      FSTC_K_OTHER = 3'h0,
      FSTC_K_MUL   = 3'h1,
      FSTC_K_DIV   = 3'h2,
      FSTC_K_SQRT  = 3'h3,
      FSTC_K_CMP   = 3'h4
   } fstc_kind_t;

   typedef enum logic [2:0] {
      FSTC_M_EXEC = 3'b001,
      FSTC_M_PEND = 3'b010,
      FSTC_M_EXCP = 3'b100
   } fstc_mode_t;

   // one op_queue entry
   typedef struct packed {
      logic [31:0] instr;
      logic [31:0] addr;
   } fstc_qent_t;

   // completion report from the arithmetic datapath
   typedef struct packed {
      fstc_kind_t  kind;
      logic [4:0]  exc;
      logic [31:0] res;
      logic [4:0]  rd;
      logic [1:0]  fcc;
      logic        a_sub;
      logic        a_zero;
      logic        b_sub;
      logic        b_zero;
      logic        r_sub;
      logic        unfin;
      logic        unimp;
   } fstc_done_t;
endpackage

// *** core/fstc_regfile.sv ***
/*
 * fstc_regfile: operand register file, two write ports, one read port
 * whose data come out of a register.
 * Assumes port b wins when both ports write one address together.
 */
`timescale 1ns/100ps
module fstc_regfile #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   input  wire logic                     clk,
   input  wire logic                     wa_en,
   input  wire logic [$clog2(DEPTH)-1:0] wa_addr,
   input  wire logic [WIDTH-1:0]         wa_data,
   input  wire logic                     wb_en,
   input  wire logic [$clog2(DEPTH)-1:0] wb_addr,
   input  wire logic [WIDTH-1:0]         wb_data,
   input  wire logic [$clog2(DEPTH)-1:0] r_addr,
   output logic [WIDTH-1:0]              r_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   // storage of 32 words of 32 bits
   always_ff @(posedge clk) begin
      if (wa_en && !(wb_en && wb_addr == wa_addr))
         mem[wa_addr] <= wa_data;
      if (wb_en)
         mem[wb_addr] <= wb_data;
      r_data <= mem[r_addr];
   end
endmodule

// *** tb/fstc_core_props.sv ***
/* fstc_core_props: concurrent checks on the status, trap and queue ports.
   Assumes it is bound to fstc_core, one clock, synchronous reset. */
`timescale 1ns/100ps
module fstc_core_props
   import fstc_pkg::*;
#(
   parameter logic [2:0] VERSION = 3'h5
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        core_issue,
   input wire logic        load_status_cmd,
   input wire logic [31:0] load_status_data,
   input wire logic        queue_store_cmd,
   input wire logic        done,
   input wire logic        exec_start,
   input wire logic        freeze,
   input wire logic        trap_req,
   input wire logic        trap_taken,
   input wire logic [31:0] store_data,
   input wire logic        store_valid,
   input wire logic        queue_out_valid,
   input wire logic [1:0]  round_mode,
   input wire fstc_mode_t  mode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // slice held as a net so that $past sees a plain signal
   wire [1:0] ld_rnd = load_status_data[31:30];
   // trap acceptance is two steps: issue while pending, then taken pulse
   sequence accept_s;
      mode == FSTC_M_PEND && core_issue;
   endsequence
   sequence taken_s;
      trap_taken && !trap_req && mode == FSTC_M_EXCP && !exec_start;
   endsequence
   reserved_zero_a: assert property (store_valid |->
      store_data[29:28] == 2'h0 && store_data[21:20] == 2'h0 && !store_data[12])
      else $error("reserved status bits not zero");
   version_fixed_a: assert property (store_valid |-> store_data[19:17] == VERSION)
      else $error("version field changed");
   queue_flag_a: assert property (
      store_valid && $past(mode) == FSTC_M_EXEC |-> !store_data[13])
      else $error("queue flag set in execution mode");
   load_round_a: assert property (
      load_status_cmd && !done |=> ##1 round_mode == $past(ld_rnd, 2))
      else $error("rounding field not loaded");
   trap_pending_a: assert property (trap_req |-> mode == FSTC_M_PEND)
      else $error("trap request outside pending mode");
   trap_accept_a: assert property (accept_s |=> taken_s)
      else $error("trap not taken on pending issue");
   drain_pop_a: assert property (
      mode == FSTC_M_EXCP && queue_store_cmd |=> queue_out_valid)
      else $error("queue store gave no entry");
   excp_exit_a: assert property (
      mode == FSTC_M_EXCP |=> mode == FSTC_M_EXCP || mode == FSTC_M_EXEC)
      else $error("bad mode after exception mode");
   freeze_end_a: assert property ($fell(freeze) |-> exec_start)
      else $error("freeze released without a start");
endmodule

bind fstc_core fstc_core_props #(.VERSION(VERSION)) u_props (.*);

// *** tb/fstc_dp_model.sv ***
/* fstc_dp_model: datapath beside fstc_core; reports one completion per
   started op after lat cycles with the class bits the bench sets.
   Assumes a trap request cancels every op still in flight. */
`timescale 1ns/100ps
module fstc_dp_model
   import fstc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       exec_start,
   input  wire fstc_qent_t exec_op,
   input  wire logic       trap_req,
   input  wire fstc_done_t info,
   input  wire logic [7:0] lat,
   output logic            done,
   output fstc_done_t      done_info
);
   logic [7:0] cnt_q;
   logic [1:0] pend_q;
   logic [4:0] rd_q;
   // a new start restarts the count: slower than a pipeline, never early
   always_ff @(posedge clk) begin
      done <= 1'b0;
      if (rst || trap_req) begin
         pend_q <= 2'h0;
         cnt_q <= 8'h00;
      end else if (exec_start) begin
         pend_q <= pend_q + 2'h1;
         cnt_q <= lat;
         rd_q <= exec_op.instr[INS_RD_LSB +: 5];
      end else if (pend_q != 2'h0 && cnt_q > 8'h01) begin
         cnt_q <= cnt_q - 8'h01;
      end else if (pend_q != 2'h0) begin
         done <= 1'b1;
         pend_q <= pend_q - 2'h1;
         cnt_q <= lat;
      end
   end
   // class bits from the bench, destination from the started op
   always_comb begin
      done_info = info;
      done_info.rd = rd_q;
   end
endmodule

// *** tb/tb_fp_status_trap_control.sv ***
/* tb_fp_status_trap_control: self-checking bench for fstc_core.
   Assumes fstc_dp_model completes started ops and the checker is bound. */
`timescale 1ns/100ps
module tb_fp_status_trap_control
   import fstc_pkg::*;
   ;
   localparam logic [2:0]  VER = 3'h6;  // arbitrary version code
   localparam logic [31:0] VW  = {12'h000, VER, 17'h00000};
   logic        clk, rst, fetch_strobe, core_issue, load_status_cmd, store_status_cmd;
   logic        queue_store_cmd, ld_we, done, exec_start, freeze, trap_req, trap_taken;
   logic        store_valid, queue_out_valid, flush_mode, saw_frz;
   logic [31:0] data_bus, addr_bus, load_status_data, ld_data, op_rdata, store_data, v;
   logic [4:0]  ld_rd, op_raddr;
   logic [1:0]  round_mode;
   logic [7:0]  lat;
   fstc_done_t  done_info, info;
   fstc_qent_t  exec_op, queue_out;
   fstc_mode_t  mode;
   int          cycles, mismatches, compares;

   fstc_core #(.VERSION(VER)) DUT (
      .clk(clk), .rst(rst), .fetch_strobe(fetch_strobe), .data_bus(data_bus),
      .addr_bus(addr_bus), .core_issue(core_issue), .load_status_cmd(load_status_cmd),
      .load_status_data(load_status_data), .store_status_cmd(store_status_cmd),
      .queue_store_cmd(queue_store_cmd), .ld_we(ld_we), .ld_rd(ld_rd), .ld_data(ld_data),
      .op_raddr(op_raddr), .done(done), .done_info(done_info), .op_rdata(op_rdata),
      .exec_start(exec_start), .exec_op(exec_op), .freeze(freeze), .trap_req(trap_req),
      .trap_taken(trap_taken), .store_data(store_data), .store_valid(store_valid),
      .queue_out(queue_out), .queue_out_valid(queue_out_valid), .round_mode(round_mode),
      .flush_mode(flush_mode), .mode(mode));
   fstc_dp_model PARTNER (
      .clk(clk), .rst(rst), .exec_start(exec_start), .exec_op(exec_op), .trap_req(trap_req),
      .info(info), .lat(lat), .done(done), .done_info(done_info));

   // 100 ns clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // hang guard, far above the run's length
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         mismatches = mismatches + 1;
         final_report();
      end
   end

   function automatic logic [31:0] mk(input logic [4:0] d, s1, s2);
      return {2'h0, d, 6'h00, s1, 9'h000, s2};
   endfunction
   // inputs move 10 ns after each edge
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk);
      #10;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic ld_st(input logic [31:0] d);
      load_status_cmd = 1'b1;
      load_status_data = d;
      tick();
      load_status_cmd = 1'b0;
   endtask
   task automatic rd_st(output logic [31:0] r);
      store_status_cmd = 1'b1;
      tick();
      store_status_cmd = 1'b0;
      r = store_data;
   endtask
   task automatic rf_rd(input logic [4:0] a, output logic [31:0] r);
      op_raddr = a;
      tick();
      r = op_rdata;
   endtask
   // fetch, two decode cycles, then the core's issue pulse
   task automatic issue(input logic [31:0] ins);
      int k;
      fetch_strobe = 1'b1;
      data_bus = ins;
      addr_bus = {ins[15:0], 16'h4000};
      tick();
      fetch_strobe = 1'b0;
      tick(2);
      core_issue = 1'b1;
      tick();
      core_issue = 1'b0;
      k = 0;
      while (exec_start !== 1'b1 && k < 100) begin
         saw_frz |= (freeze === 1'b1);
         tick();
         k++;
      end
      cmp(exec_op.instr, ins);
      cmp(exec_op.addr, {ins[15:0], 16'h4000});
   endtask
   task automatic wait_done();
      int k;
      k = 0;
      while (done !== 1'b1 && k < 100) begin
         tick();
         k++;
      end
      tick();
   endtask

   task automatic t_reset();
      rd_st(v);
      cmp(v, VW);
   endtask
   task automatic t_load();
      ld_st(32'hFFFFFFFF);
      rd_st(v);
      cmp(v, 32'hCFC00FFF | VW);
      for (int i = 0; i < 4; i++) begin
         ld_st({i[1:0], 30'h00000000});
         tick();
         cmp(32'(round_mode), i);
      end
   endtask
   // two masked ops: current flags replaced, accrued flags ORed
   task automatic t_masked();
      ld_st(32'h00000000);
      info = '0;
      info.exc = 5'h09;
      info.res = 32'h12345678;
      issue(mk(5'h03, 5'h01, 5'h02));
      wait_done();
      info.exc = 5'h04;
      issue(mk(5'h04, 5'h01, 5'h02));
      wait_done();
      rd_st(v);
      cmp(v, 32'h000001A4 | VW);
      rf_rd(5'h03, v);
      cmp(v, 32'h12345678);
   endtask
   task automatic t_compare();
      for (int i = 0; i < 4; i++) begin
         info = '0;
         info.kind = FSTC_K_CMP;
         info.fcc = i[1:0];
         issue(mk(5'h0A, 5'h0B, 5'h0C));
         wait_done();
         rd_st(v);
         cmp(32'(v[11:10]), i);
      end
   endtask
   // abrupt underflow table: mul, div, sqrt class cases
   task automatic t_flush();
      fstc_kind_t  kd [6] = '{FSTC_K_MUL, FSTC_K_DIV, FSTC_K_SQRT, FSTC_K_MUL,
                             FSTC_K_DIV, FSTC_K_DIV};
      logic [31:0] er [6] = '{RES_ZERO, RES_INF, RES_ZERO, RES_ZERO, RES_NAN, RES_ZERO};
      logic [4:0]  ex [6] = '{5'h00, 5'h02, 5'h00, 5'h04, 5'h10, 5'h00};
      logic [5:0]  as = 6'h35;
      logic [5:0]  bs = 6'h12;
      ld_st(32'h00400000);
      tick();
      cmp(32'(flush_mode), 32'h00000001);
      for (int i = 0; i < 6; i++) begin
         info = '0;
         info.kind = kd[i];
         info.res = 32'h00000123;
         info.a_sub = as[i];
         info.b_sub = bs[i];
         info.r_sub = (i == 3);
         issue(mk(5'h14, 5'h15, 5'h16));
         wait_done();
         rd_st(v);
         cmp(32'(v[4:0]), 32'(ex[i]));
         rf_rd(5'h14, v);
         cmp(v, er[i]);
      end
   endtask
   // second op reads the first op's destination
   task automatic t_freeze();
      lat = 8'h1E;
      saw_frz = 1'b0;
      issue(mk(5'h07, 5'h01, 5'h02));
      issue(mk(5'h08, 5'h07, 5'h02));
      cmp(32'(saw_frz), 32'h00000001);
      wait_done();
      lat = 8'h03;
   endtask
   task automatic t_trap();
      ld_we = 1'b1;
      ld_rd = 5'h05;
      ld_data = 32'hA5A5A5A5;
      tick();
      ld_we = 1'b0;
      ld_st(32'h08000000);
      info = '0;
      info.exc = 5'h10;
      info.res = 32'h0000BEEF;
      lat = 8'h08;
      issue(mk(5'h05, 5'h01, 5'h02));
      issue(mk(5'h06, 5'h03, 5'h04));
      wait_done();
      rd_st(v);
      cmp(v, 32'h08006010 | VW);
      cmp(32'(trap_req), 32'h00000001);
      rf_rd(5'h05, v);
      cmp(v, 32'hA5A5A5A5);
      core_issue = 1'b1;
      tick();
      core_issue = 1'b0;
      cmp(32'(mode), 32'(FSTC_M_EXCP));
      queue_store_cmd = 1'b1;
      tick();
      queue_store_cmd = 1'b0;
      cmp(queue_out.instr, mk(5'h06, 5'h03, 5'h04));
      tick(2);
      cmp(32'(mode), 32'(FSTC_M_EXEC));
      lat = 8'h03;
   endtask

   task automatic final_report();
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // reset, then the scenarios
   initial begin
      rst = 1'b1;
      {fetch_strobe, core_issue, load_status_cmd, store_status_cmd, queue_store_cmd, ld_we,
       saw_frz} = 7'h00;
      {data_bus, addr_bus, load_status_data, ld_data} = 128'h0;
      {ld_rd, op_raddr} = 10'h000;
      info = '0;
      lat = 8'h03;
      {cycles, mismatches, compares} = 96'h0;
      tick(2);
      rst = 1'b0;
      t_reset();
      t_load();
      t_masked();
      t_compare();
      t_flush();
      t_freeze();
      t_trap();
      final_report();
   end
endmodule
